// [shared/purge_map.svh]
// Address map, field positions, reset values and timing counts of the purge sequencer
`ifndef PURGE_MAP_SVH
`define PURGE_MAP_SVH

// Timebase: one tick per second from the 40 MHz clock
`define CLK_HZ 40000000
`define TICK_S 1
`define SEC_CYCLES (`CLK_HZ * `TICK_S)

// Wishbone byte addresses
`define ADDR_CTRL 8'h00
`define ADDR_CYCLE 8'h04
`define ADDR_POST 8'h08
`define ADDR_STATUS 8'h0c
`define ADDR_LEFT 8'h10

// Control register fields
`define CTRL_VARIANT_B 0
`define CTRL_FILTER_FIT 1
`define CTRL_SAMPLE_FIT 2
`define CTRL_MANUAL 3

// Status register fields
`define STAT_BUSY 4
`define STAT_PLUGGED 5
`define STAT_ARMED 6
`define STAT_WAITING 7

// Reset values
`define CTRL_RESET 3'h6
`define CYCLE_DEFAULT_H 4
`define CYCLE_DEFAULT_S (`CYCLE_DEFAULT_H * 3600)
`define POST_DEFAULT_S 16'h0096

// Step durations in seconds
`define FILTER_A_S 16'h000a
`define TUBE_A_S 16'h000e
`define VENT_S 16'h0006
`define SWITCH_B_S 16'h0002
`define FILTER_B_S 16'h0004
`define TUBE_B_S 16'h0008
`define FAULT_WAIT_S 5'h1e
`define TUBE_LONG_AT 16'h000a

`endif

// [shared/purge_pkg.sv]
// Types shared by the purge sequencer
package purge_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SWITCH,
      ST_FILTER,
      ST_TUBE,
      ST_VENT,
      ST_POST
   } step_t;

endpackage

// [rtl/purge_timebase.sv]
// One-second tick generator with restart
`timescale 1ns/1ps
`include "purge_map.svh"

module purge_timebase #(
   parameter int TICK_CYCLES = `SEC_CYCLES
) (
   input  wire logic mclk,    // System clock
   input  wire logic resetn,  // Synchronous reset, active low
   input  wire logic restart, // Realign the second boundary
   output logic      secTick  // One-cycle pulse per second
);

   logic [25:0] count;
   wire         wrap = (count == 26'(TICK_CYCLES - 1));

   always_ff @(posedge mclk) begin
      if (!resetn || restart || wrap) begin
         count <= 26'h0000000;
      end else begin
         count <= count + 26'h0000001;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn || restart) begin
         secTick <= 1'b0;
      end else begin
         secTick <= wrap;
      end
   end

endmodule

// [rtl/filter_back_purge_sequencer.sv]
// Back-purge sequencer for a probe filter, with a Wishbone register slave
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "purge_map.svh"

module filter_back_purge_sequencer #(
   parameter int SEC_CYCLES = `SEC_CYCLES
) (
   input  wire logic        mclk,              // 40 MHz clock
   input  wire logic        resetn,            // Synchronous reset, active low
   input  wire logic        wb_cyc_i,          // Wishbone cycle
   input  wire logic        wb_stb_i,          // Wishbone strobe
   input  wire logic        wb_we_i,           // Wishbone write enable
   input  wire logic [7:0]  wb_adr_i,          // Byte address
   input  wire logic [3:0]  wb_sel_i,          // Byte enables
   input  wire logic [31:0] wb_dat_i,          // Write data
   output logic      [31:0] wb_dat_o,          // Read data
   output logic             wb_ack_o,          // Acknowledge
   input  wire logic        flowFault,         // Flow below limit
   input  wire logic        softkeyStart,      // Local start key
   input  wire logic        remoteStart,       // Remote start input
   output logic             impulseAirValve,   // A: impulse air
   output logic             filterPurgeValveA, // A: filter purge
   output logic             tubePurgeValveA,   // A: tube purge
   output logic             ventValveA,        // A: vent
   output logic             sampleGasValve,    // A: sample gas path
   output logic             filterPurgeValveB, // B: filter purge
   output logic             tubePurgeValveB,   // B: tube purge
   output logic             ventValveB,        // B: vent
   output logic             calibrationValveOutput, // High = measure
   output logic             purgeMessage,      // Purge active message
   output logic             maintenanceStatus, // Maintenance mode
   output logic             pluggedLineStatus  // Sample line blocked flag
);
   import purge_pkg::*;

   step_t       state;
   step_t       next_state;
   logic [2:0]  ctrl;
   logic [23:0] cycleTime;
   logic [15:0] postTime;
   logic [23:0] cycleLeft;
   logic [15:0] secCount;
   logic [4:0]  waitCount;
   logic        faultArmed;
   logic        faultRun;
   logic        faultWaiting;
   logic        softPrev;
   logic        remotePrev;
   logic        secTick;

   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] wdat,
                                              input logic [3:0]  sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = wdat[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Register slave decode
   wire wbReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // Writes land on the acknowledge edge, while the master still holds the request
   wire wbWrite = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   wire selCtrl = (wb_adr_i == `ADDR_CTRL);
   wire selCyc  = (wb_adr_i == `ADDR_CYCLE);
   wire selPost = (wb_adr_i == `ADDR_POST);
   wire selStat = (wb_adr_i == `ADDR_STATUS);
   wire selLeft = (wb_adr_i == `ADDR_LEFT);

   wire [31:0] ctrlMerged = mergeBytes({29'h0, ctrl}, wb_dat_i, wb_sel_i);
   wire [31:0] cycMerged  = mergeBytes({8'h00, cycleTime}, wb_dat_i, wb_sel_i);
   wire [31:0] postMerged = mergeBytes({16'h0000, postTime}, wb_dat_i, wb_sel_i);

   wire cfgVariantB = ctrl[`CTRL_VARIANT_B];
   wire cfgFilterFit = ctrl[`CTRL_FILTER_FIT];
   wire cfgSampleFit = ctrl[`CTRL_SAMPLE_FIT];
   wire inA = !cfgVariantB;

   wire idle = (state == ST_IDLE);
   wire busy = !idle;

   wire [31:0] statusWord = {24'h000000, faultWaiting, faultArmed,
                             pluggedLineStatus, busy, 1'b0, 3'(state)};

   wire [31:0] readMux = selCtrl ? {29'h0, ctrl} :
                         selCyc  ? {8'h00, cycleTime} :
                         selPost ? {16'h0000, postTime} :
                         selStat ? statusWord :
                         selLeft ? {8'h00, cycleLeft} : 32'h00000000;

   // Start requests; edges so a held key starts one purge only
   wire regManual = wbWrite && selCtrl && wb_sel_i[0] && wb_dat_i[`CTRL_MANUAL];
   wire manualReq = (softkeyStart && !softPrev)
                 || (remoteStart && !remotePrev)
                 || regManual;
   wire autoOk = !pluggedLineStatus && !faultWaiting;
   wire cycleExpire = secTick && (cycleLeft == 24'h000000);
   wire faultStart = idle && autoOk && faultArmed && flowFault;
   wire cycleStart = idle && autoOk && cycleExpire;
   wire startReq = idle && (manualReq || faultStart || cycleStart);

   // Step timing
   wire [15:0] stepDur =
      (state == ST_SWITCH) ? `SWITCH_B_S :
      (state == ST_FILTER) ? (inA ? `FILTER_A_S : `FILTER_B_S) :
      (state == ST_TUBE)   ? (inA ? `TUBE_A_S : `TUBE_B_S) :
      (state == ST_VENT)   ? `VENT_S : postTime;
   wire stepLast = busy && secTick && (secCount == stepDur - 16'h0001);
   wire purgeDone = (state == ST_POST) && stepLast;
   wire waitDone = faultWaiting && idle && secTick
                   && (waitCount == `FAULT_WAIT_S - 5'h01);

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (startReq) begin
               next_state = cfgVariantB ? ST_SWITCH : ST_FILTER;
            end
         end
         ST_SWITCH: begin
            if (stepLast) begin
               next_state = ST_FILTER;
            end
         end
         ST_FILTER: begin
            if (stepLast) begin
               next_state = ST_TUBE;
            end
         end
         ST_TUBE: begin
            if (stepLast) begin
               next_state = ST_VENT;
            end
         end
         ST_VENT: begin
            if (stepLast) begin
               next_state = ST_POST;
            end
         end
         ST_POST: begin
            if (stepLast) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Output decode per step and variant
   wire inFilter = (state == ST_FILTER);
   wire inTube = (state == ST_TUBE);
   wire inVent = (state == ST_VENT);
   wire measurePos = idle || (state == ST_POST);
   wire tubeLong = (secCount >= `TUBE_LONG_AT);

   wire next_impulse = inA && ((inFilter && secCount[1])
                             || (inTube && (secCount[1] || tubeLong)));
   wire next_filterA = inA && cfgFilterFit && (inFilter || inVent);
   wire next_tubeA = inA && inTube;
   wire next_ventA = inA && (measurePos || inVent);
   wire next_sample = inA && cfgSampleFit && measurePos;
   wire next_filterB = cfgVariantB && cfgFilterFit && inFilter
                       && (secCount < 16'h0002);
   wire next_tubeB = cfgVariantB && inTube
                     && (secCount[2] || !secCount[1]);
   wire next_ventB = cfgVariantB && inVent;
   wire next_cal = measurePos;

   purge_timebase #(
      .TICK_CYCLES(SEC_CYCLES)
   ) u_timebase (
      .mclk    (mclk),
      .resetn  (resetn),
      .restart (startReq),
      .secTick (secTick)
   );

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wbReq;
         wb_dat_o <= wbReq ? readMux : 32'h00000000;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ctrl <= `CTRL_RESET;
         cycleTime <= 24'(`CYCLE_DEFAULT_S);
         postTime <= `POST_DEFAULT_S;
      end else if (wbWrite) begin
         if (selCtrl) ctrl <= ctrlMerged[2:0];
         if (selCyc) cycleTime <= cycMerged[23:0];
         if (selPost) postTime <= postMerged[15:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         state <= ST_IDLE;
         secCount <= 16'h0000;
         softPrev <= 1'b0;
         remotePrev <= 1'b0;
      end else begin
         state <= next_state;
         softPrev <= softkeyStart;
         remotePrev <= remoteStart;
         if (startReq || stepLast) secCount <= 16'h0000;
         else if (busy && secTick) secCount <= secCount + 16'h0001;
      end
   end

   // Cycle timer runs in every state, so a lapse in a purge is simply dropped
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cycleLeft <= 24'(`CYCLE_DEFAULT_S - 1);
      end else if (cycleExpire || faultStart || (wbWrite && selCyc)) begin
         cycleLeft <= (wbWrite && selCyc) ? cycMerged[23:0] - 24'h000001
                                          : cycleTime - 24'h000001;
      end else if (secTick) begin
         cycleLeft <= cycleLeft - 24'h000001;
      end
   end

   // Fault bookkeeping
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         faultArmed <= 1'b1;
         faultRun <= 1'b0;
         faultWaiting <= 1'b0;
         waitCount <= 5'h00;
         pluggedLineStatus <= 1'b0;
      end else begin
         if (!flowFault) faultArmed <= 1'b1;
         else if (faultStart) faultArmed <= 1'b0;
         if (startReq) faultRun <= faultStart;
         if (purgeDone && faultRun) begin
            faultWaiting <= 1'b1;
            waitCount <= 5'h00;
         end else if (waitDone) begin
            faultWaiting <= 1'b0;
         end else if (faultWaiting && idle && secTick) begin
            waitCount <= waitCount + 5'h01;
         end
         if (waitDone && flowFault) pluggedLineStatus <= 1'b1;
         else if (!flowFault) pluggedLineStatus <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         impulseAirValve <= 1'b0;
         filterPurgeValveA <= 1'b0;
         tubePurgeValveA <= 1'b0;
         ventValveA <= 1'b0;
         sampleGasValve <= 1'b0;
         filterPurgeValveB <= 1'b0;
         tubePurgeValveB <= 1'b0;
         ventValveB <= 1'b0;
         calibrationValveOutput <= 1'b1;
         purgeMessage <= 1'b0;
         maintenanceStatus <= 1'b0;
      end else begin
         impulseAirValve <= next_impulse;
         filterPurgeValveA <= next_filterA;
         tubePurgeValveA <= next_tubeA;
         ventValveA <= next_ventA;
         sampleGasValve <= next_sample;
         filterPurgeValveB <= next_filterB;
         tubePurgeValveB <= next_tubeB;
         ventValveB <= next_ventB;
         calibrationValveOutput <= next_cal;
         purgeMessage <= busy;
         maintenanceStatus <= busy;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   AST_MSG_MAINT: assert property (
      ##1 (purgeMessage == maintenanceStatus) && (purgeMessage == $past(busy)))
      else $error("message or maintenance out of step");

   AST_CAL_POS: assert property (
      !calibrationValveOutput |-> purgeMessage && $past(inFilter || inTube
                                  || inVent || state == ST_SWITCH))
      else $error("calibrate selected outside a purge step");

   AST_IDLE_A: assert property (
      ##1 $past(idle && inA) |-> ventValveA && !impulseAirValve
                                   && !filterPurgeValveA && !tubePurgeValveA)
      else $error("variant A idle valves wrong");

   AST_PULSE_A: assert property (
      (inFilter && inA && secCount == 16'h0000) |=> !impulseAirValve)
      else $error("impulse must open with a pause");

   AST_FAULT_START: assert property (
      faultStart |=> (state == ST_FILTER || state == ST_SWITCH) && !faultArmed)
      else $error("fault did not start one purge");

   AST_NO_RESTART: assert property (
      (busy && !stepLast) |=> (state == $past(state)))
      else $error("running purge disturbed");

   AST_PLUGGED: assert property (
      $rose(pluggedLineStatus) |-> $past(flowFault) && $past(waitDone))
      else $error("plugged flag without lasting fault");

   AST_MANUAL: assert property (
      (idle && manualReq && pluggedLineStatus) |=> busy)
      else $error("manual start refused");

   AST_SWITCH_B: assert property (
      (state == ST_SWITCH && stepLast) |=> inFilter ##1 !calibrationValveOutput)
      else $error("switch-over step wrong");

   AST_FILTER_FIT: assert property (
      !$past(cfgFilterFit) |-> !filterPurgeValveB && !filterPurgeValveA)
      else $error("absent filter valve driven");

endmodule

// [testbench/purge_partner.sv]
// Remote start station and valve pulse counters facing the purge sequencer
`timescale 1ns/1ps

module purge_partner (
   input  wire logic       mclk,            // System clock
   input  wire logic       resetn,          // Synchronous reset, active low
   input  wire logic       pressReq,        // Bench asks for a remote start
   input  wire logic       impulseAirValve, // Watched impulse valve
   input  wire logic       tubePurgeValveB, // Watched tube valve, variant B
   output logic            remoteStart,     // Remote digital start input
   output logic      [7:0] impulseCount,    // Impulse valve openings seen
   output logic      [7:0] tubeBCount       // Tube valve B openings seen
);
   logic [1:0] hold;
   logic       lastImp;
   logic       lastTube;

   // Remote input stays up a few cycles, as a polled field-bus bit would
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         hold         <= 2'h0;
         remoteStart  <= 1'b0;
         lastImp      <= 1'b0;
         lastTube     <= 1'b0;
         impulseCount <= 8'h00;
         tubeBCount   <= 8'h00;
      end else begin
         if (pressReq) begin
            hold <= 2'h2;
         end else if (hold != 2'h0) begin
            hold <= hold - 2'h1;
         end
         remoteStart <= pressReq | (hold != 2'h0);
         lastImp     <= impulseAirValve;
         lastTube    <= tubePurgeValveB;
         if (impulseAirValve && !lastImp) begin
            impulseCount <= impulseCount + 8'h01;
         end
         if (tubePurgeValveB && !lastTube) begin
            tubeBCount <= tubeBCount + 8'h01;
         end
      end
   end
endmodule

// [testbench/filter_back_purge_sequencer_tb.sv]
// Self-checking bench for the back-purge sequencer
`timescale 1ns/1ps
`include "purge_map.svh"

module filter_back_purge_sequencer_tb;
   import purge_pkg::*;
   logic        mclk = 1'b0;
   logic        resetn = 1'b0;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic        ack, remoteStart, flowFault = 1'b0, softkeyStart = 1'b0, pressReq = 1'b0;
   logic        iav, fa, ta, va, sg, fb, tb, vb, cal, msg, mnt, plg;
   logic [7:0]  impCnt, tubeCnt;
   logic [10:0] outs;
   int          n_errors = 0, num_checks = 0, cycles = 0, seed = 6, t0;
   logic [2:0]  cfgT [4] = '{3'h6, 3'h7, 3'h4, 3'h1};
   int          postT [4] = '{3, 1, 2, 1};
   int          srcT [4] = '{0, 1, 2, 0};

   assign outs = {iav, fa, ta, va, sg, fb, tb, vb, cal, msg, mnt};
   always #12.5 mclk = ~mclk;

   filter_back_purge_sequencer #(.SEC_CYCLES(4)) u_filter_back_purge_sequencer (
      .mclk(mclk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .flowFault(flowFault), .softkeyStart(softkeyStart), .remoteStart(remoteStart),
      .impulseAirValve(iav), .filterPurgeValveA(fa), .tubePurgeValveA(ta), .ventValveA(va),
      .sampleGasValve(sg), .filterPurgeValveB(fb), .tubePurgeValveB(tb), .ventValveB(vb),
      .calibrationValveOutput(cal), .purgeMessage(msg), .maintenanceStatus(mnt),
      .pluggedLineStatus(plg));

   purge_partner u_purge_partner (
      .mclk(mclk), .resetn(resetn), .pressReq(pressReq), .impulseAirValve(iav),
      .tubePurgeValveB(tb), .remoteStart(remoteStart), .impulseCount(impCnt),
      .tubeBCount(tubeCnt));

   // Expected outputs s whole seconds into a purge; past the end the idle pattern
   function automatic logic [10:0] expOut(input logic [2:0] cfg, input int post, input int s);
      logic i, a1, a2, a3, g, b1, b2, b3, c, m;
      {i, a1, a2, a3, g, b1, b2, b3} = 8'h00;
      c = 1'b1;
      m = (s < (cfg[0] ? 20 : 30) + post);
      if (!cfg[0]) begin
         a3 = 1'b1;
         g  = cfg[2];
         if (s < 10) begin
            {i, a1, a3, g, c} = {s % 4 >= 2, 4'h8};
         end else if (s < 24) begin
            {i, a2, a3, g, c} = {s >= 20 || (s - 10) % 4 >= 2, 4'h8};
         end else if (s < 30) begin
            {a1, g, c} = 3'h4;
         end
         a1 = a1 & cfg[1];
      end else begin
         c = (s >= 20);
         b1 = (s >= 2 && s < 4) & cfg[1];
         b2 = (s >= 6 && s < 8) || (s >= 10 && s < 14);
         b3 = (s >= 14 && s < 20);
      end
      return {i, a1, a2, a3, g, b1, b2, b3, c, m, m};
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do @(posedge mclk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic waitMsg(input logic v, input int lim);
      int n = 0;
      while (msg !== v && n < lim) begin
         @(posedge mclk);
         n++;
      end
      check(msg, v, "purge message");
   endtask

   task automatic press();
      @(posedge mclk);
      softkeyStart <= 1'b1;
      @(posedge mclk);
      softkeyStart <= 1'b0;
   endtask

   // Source 0 softkey, 1 remote input, 2 control register bit
   task automatic runSeq(input logic [2:0] cfg, input int post, input int src);
      logic [7:0] i0, k0;
      bus(1'b1, `ADDR_POST, post);
      bus(1'b1, `ADDR_CTRL, {29'h0, cfg});
      i0 = impCnt;
      k0 = tubeCnt;
      if (src == 2) begin
         bus(1'b1, `ADDR_CTRL, {28'h0, 1'b1, cfg});
         repeat (4) @(posedge mclk);
      end else if (src == 1) begin
         @(posedge mclk);
         pressReq <= 1'b1;
         @(posedge mclk);
         pressReq <= 1'b0;
         repeat (5) @(posedge mclk);
      end else begin
         press();
         repeat (4) @(posedge mclk);
      end
      for (int s = 0; s <= (cfg[0] ? 20 : 30) + post + 1; s++) begin
         check(outs, expOut(cfg, post, s), "valves");
         if (s == 12) begin
            press();
            repeat (2) @(posedge mclk);
         end else begin
            repeat (4) @(posedge mclk);
         end
      end
      check(impCnt - i0, cfg[0] ? 0 : 5, "impulses");
      check(tubeCnt - k0, cfg[0] ? 2 : 0, "tube b pulses");
      bus(1'b0, `ADDR_STATUS, 0);
      check(q[4:0], 0, "status idle");
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 30000) begin
         n_errors++;
         stop_test();
      end
   end

   initial begin
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      bus(1'b0, `ADDR_CTRL, 0);
      check(q, `CTRL_RESET, "ctrl reset");
      bus(1'b0, `ADDR_CYCLE, 0);
      check(q, `CYCLE_DEFAULT_S, "cycle reset");
      bus(1'b0, `ADDR_POST, 0);
      check(q, `POST_DEFAULT_S, "post reset");
      bus(1'b1, 8'h14, 32'hffffffff);
      bus(1'b0, 8'h14, 0);
      check(q, 0, "unmapped");
      bus(1'b1, `ADDR_STATUS, 32'hff);
      bus(1'b0, `ADDR_STATUS, 0);
      check(q[4:0], 0, "status read only");
      check(outs, expOut(3'h6, 150, 999), "idle");
      $display("test registers done");
      for (int k = 0; k < 8; k++) begin
         if (k < 4) runSeq(cfgT[k], postT[k], srcT[k]);
         else runSeq(3'($random(seed)), 1 + ($random(seed) & 3), int'($unsigned($random(seed)) % 3));
      end
      $display("test sequences done");
      bus(1'b1, `ADDR_CTRL, 32'h6);
      flowFault <= 1'b1;
      waitMsg(1'b1, 20);
      waitMsg(1'b0, 200);
      repeat (100) begin
         @(posedge mclk);
         check({plg, msg}, 0, "no retrigger");
      end
      repeat (40) @(posedge mclk);
      check(plg, 1'b1, "plugged");
      bus(1'b0, `ADDR_STATUS, 0);
      check(q[7:4], 4'h2, "status plugged");
      bus(1'b1, `ADDR_CYCLE, 40);
      repeat (200) begin
         @(posedge mclk);
         check(msg, 1'b0, "blocked start");
      end
      press();
      waitMsg(1'b1, 10);
      waitMsg(1'b0, 200);
      flowFault <= 1'b0;
      repeat (4) @(posedge mclk);
      check(plg, 1'b0, "plug clear");
      $display("test fault done");
      waitMsg(1'b1, 200);
      t0 = cycles;
      waitMsg(1'b0, 200);
      waitMsg(1'b1, 200);
      check((cycles - t0 >= 158) && (cycles - t0 <= 162), 1, "cycle interval");
      $display("test timer done");
      stop_test();
   end
endmodule
